// ===== shared/xcvr_rst_regs.svh
`ifndef XCVR_RST_REGS_SVH
`define XCVR_RST_REGS_SVH

// wishbone register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_RATE 8'h08
// control fields
`define CTRL_START 0
`define CTRL_MANUAL 1
`define CTRL_PCIE 2
`define CTRL_RECONF 3
`define RATE_W 2
`define RATE_RESET 2'h0
// timing in ns (rx pulse in cycles) and the 100 MHz clock period
`define CLK_NS 10
`define T_PWRDN_NS 1000
`define T_RXDIG_NS 4000
`define T_LTD_NS 15000
`define T_RXPULSE_CYC 2
// cycle counts rounded up
`define CYC_PWRDN ((`T_PWRDN_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_RXDIG ((`T_RXDIG_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_LTD ((`T_LTD_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ===== shared/xcvr_rst_pkg.sv
package xcvr_rst_pkg;
  typedef enum {
    ST_IDLE, ST_PWRDN, ST_TXLOCK, ST_RXLOCK, ST_RXWAIT, ST_LTD_WAIT, ST_RUN,
    ST_PCIE_LOST, ST_PCIE_DATA, ST_PCIE_WAIT, ST_PCIE_PULSE, ST_RECONF, ST_RECONF_BUSY
  } seq_state_t;
  // resets and cdr controls toward the transceiver
  typedef struct packed {
    logic pll_powerdown;
    logic tx_logic_reset;
    logic rx_frontend_reset;
    logic rx_logic_reset;
    logic lock_to_ref;
    logic lock_to_data;
  } xcvr_ctrl_t;
  // flags back from the transceiver
  typedef struct packed {
    logic pll_locked;
    logic rx_ref_locked;
    logic rx_data_locked;
    logic busy;
  } xcvr_stat_t;
endpackage : xcvr_rst_pkg

// ===== design/xcvr_rst_seq.sv
`timescale 1ns/1ps
`include "xcvr_rst_regs.svh"
module xcvr_rst_seq #(
  parameter int CNT_W = 16,
  parameter int PWRDN_CYC = `CYC_PWRDN,
  parameter int RXDIG_CYC = `CYC_RXDIG,
  parameter int LTD_CYC = `CYC_LTD
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire xcvr_rst_pkg::xcvr_stat_t i_stat,
  output xcvr_rst_pkg::xcvr_ctrl_t o_ctrl,
  output logic [`RATE_W-1:0] o_rate_sel,
  output logic o_reconf_commit,
  output logic o_rx_data_valid
);
  import xcvr_rst_pkg::*;

  seq_state_t state_r, state_nxt;
  xcvr_ctrl_t ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic manual_r, manual_nxt;
  logic pcie_r, pcie_nxt;
  logic start_r, start_nxt;
  logic reconf_r, reconf_nxt;
  logic [`RATE_W-1:0] rate_r, rate_nxt;
  logic [`RATE_W-1:0] rate_out_r, rate_out_nxt;
  logic commit_r, commit_nxt;
  logic valid_r, valid_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic pcie_normal_r, pcie_normal_nxt;
  logic wr_req;
  logic rd_req;
  logic cnt_done_pwrdn;
  logic cnt_done_rxdig;
  logic cnt_done_ltd;

  // wishbone decode and counter compares
  assign wr_req = i_wb_cyc && i_wb_stb && i_wb_we && !ack_r;
  assign rd_req = i_wb_cyc && i_wb_stb && !i_wb_we && !ack_r;
  assign cnt_done_pwrdn = (cnt_r >= CNT_W'(PWRDN_CYC - 1));
  assign cnt_done_rxdig = (cnt_r >= CNT_W'(RXDIG_CYC - 1));
  assign cnt_done_ltd = (cnt_r >= CNT_W'(LTD_CYC - 1));

  // register slave: one-cycle ack, unmapped reads zero
  always_comb begin
    ack_nxt = i_wb_cyc && i_wb_stb && !ack_r;
    rdat_nxt = rdat_r;
    manual_nxt = manual_r;
    pcie_nxt = pcie_r;
    start_nxt = 1'b0;
    reconf_nxt = 1'b0;
    rate_nxt = rate_r;
    if (wr_req && i_wb_adr == `REG_CTRL && i_wb_sel[0]) begin
      start_nxt = i_wb_dat[`CTRL_START];
      manual_nxt = i_wb_dat[`CTRL_MANUAL];
      pcie_nxt = i_wb_dat[`CTRL_PCIE];
      reconf_nxt = i_wb_dat[`CTRL_RECONF];
    end
    if (wr_req && i_wb_adr == `REG_RATE && i_wb_sel[0]) begin
      rate_nxt = i_wb_dat[`RATE_W-1:0];
    end
    if (rd_req) begin
      case (i_wb_adr)
        `REG_CTRL: rdat_nxt = {29'h0, pcie_r, manual_r, 1'b0};
        `REG_STATUS: rdat_nxt = {16'h0, 4'(state_r), 4'h0, i_stat, valid_r, 1'b0, ctrl_r[1:0]};
        `REG_RATE: rdat_nxt = {30'h0, rate_r};
        default: rdat_nxt = 32'h0;
      endcase
    end
  end

  // sequencer: one state machine per channel instance
  always_comb begin
    state_nxt = state_r;
    ctrl_nxt = ctrl_r;
    cnt_nxt = cnt_r + CNT_W'(1);
    rate_out_nxt = rate_out_r;
    commit_nxt = 1'b0;
    valid_nxt = valid_r;
    pcie_normal_nxt = pcie_normal_r;
    case (state_r)
      ST_IDLE: begin
        ctrl_nxt = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
        cnt_nxt = '0;
        if (start_r) begin
          state_nxt = ST_PWRDN;
        end
      end
      ST_PWRDN: begin
        // lock-to-ref held through power-down; auto mode lets go at release
        if (cnt_done_pwrdn) begin
          ctrl_nxt.pll_powerdown = 1'b0;
          ctrl_nxt.lock_to_ref = manual_r;
          state_nxt = ST_TXLOCK;
        end
      end
      ST_TXLOCK: begin
        // tx release also waits out busy, same as after a rate change
        if (i_stat.pll_locked && !i_stat.busy) begin
          ctrl_nxt.tx_logic_reset = 1'b0;
        end
        if (!i_stat.busy) begin
          ctrl_nxt.rx_frontend_reset = 1'b0;
        end
        if (!ctrl_r.tx_logic_reset && !ctrl_r.rx_frontend_reset) begin
          state_nxt = ST_RXLOCK;
        end
        cnt_nxt = '0;
      end
      ST_RXLOCK: begin
        cnt_nxt = '0;
        if (pcie_r && !pcie_normal_r && i_stat.rx_ref_locked) begin
          ctrl_nxt.rx_logic_reset = 1'b0;
          valid_nxt = 1'b1;
          pcie_normal_nxt = 1'b1;
          state_nxt = ST_RUN;
        end else if (!pcie_r && manual_r && i_stat.rx_ref_locked) begin
          state_nxt = ST_LTD_WAIT;
        end else if (!pcie_r && !manual_r && i_stat.rx_data_locked) begin
          state_nxt = ST_RXWAIT;
        end
      end
      ST_LTD_WAIT: begin
        if (cnt_done_ltd) begin
          ctrl_nxt.lock_to_ref = 1'b0;
          ctrl_nxt.lock_to_data = 1'b1;
          cnt_nxt = '0;
          state_nxt = ST_RXWAIT;
        end
      end
      ST_RXWAIT: begin
        if (cnt_done_rxdig) begin
          ctrl_nxt.rx_logic_reset = 1'b0;
          valid_nxt = 1'b1;
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        cnt_nxt = '0;
        if (reconf_r) begin
          rate_out_nxt = rate_r;
          ctrl_nxt.tx_logic_reset = 1'b1;
          state_nxt = ST_RECONF;
        end else if (pcie_r && pcie_normal_r && !i_stat.rx_data_locked) begin
          valid_nxt = 1'b0;
          state_nxt = ST_PCIE_LOST;
        end
      end
      ST_PCIE_LOST: begin
        if (i_stat.rx_ref_locked) begin
          state_nxt = ST_PCIE_DATA;
        end
      end
      ST_PCIE_DATA: begin
        cnt_nxt = '0;
        if (i_stat.rx_data_locked) begin
          state_nxt = ST_PCIE_WAIT;
        end
      end
      ST_PCIE_WAIT: begin
        if (cnt_done_rxdig) begin
          ctrl_nxt.rx_logic_reset = 1'b1;
          cnt_nxt = '0;
          state_nxt = ST_PCIE_PULSE;
        end
      end
      ST_PCIE_PULSE: begin
        if (cnt_r >= CNT_W'(`T_RXPULSE_CYC - 1)) begin
          ctrl_nxt.rx_logic_reset = 1'b0;
          valid_nxt = 1'b1;
          state_nxt = ST_RUN;
        end
      end
      ST_RECONF: begin
        commit_nxt = 1'b1;
        state_nxt = ST_RECONF_BUSY;
        cnt_nxt = '0;
      end
      ST_RECONF_BUSY: begin
        // wait one cycle for busy to rise before trusting its fall
        if (cnt_r != '0 && !i_stat.busy) begin
          ctrl_nxt.tx_logic_reset = 1'b0;
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (cnt_r == '1) begin
      cnt_nxt = cnt_r;
    end
  end

  // state registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      ctrl_r <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
      cnt_r <= '0;
      manual_r <= 1'b0;
      pcie_r <= 1'b0;
      start_r <= 1'b0;
      reconf_r <= 1'b0;
      rate_r <= `RATE_RESET;
      rate_out_r <= `RATE_RESET;
      commit_r <= 1'b0;
      valid_r <= 1'b0;
      ack_r <= 1'b0;
      rdat_r <= 32'h0;
      pcie_normal_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctrl_r <= ctrl_nxt;
      cnt_r <= cnt_nxt;
      manual_r <= manual_nxt;
      pcie_r <= pcie_nxt;
      start_r <= start_nxt;
      reconf_r <= reconf_nxt;
      rate_r <= rate_nxt;
      rate_out_r <= rate_out_nxt;
      commit_r <= commit_nxt;
      valid_r <= valid_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
      pcie_normal_r <= pcie_normal_nxt;
    end
  end

  // outputs straight from flops
  assign o_ctrl = ctrl_r;
  assign o_rate_sel = rate_out_r;
  assign o_reconf_commit = commit_r;
  assign o_rx_data_valid = valid_r;
  assign o_wb_ack = ack_r;
  assign o_wb_dat = rdat_r;
endmodule : xcvr_rst_seq

// ===== testbench/xcvr_rst_seq_properties.sv
`timescale 1ns/1ps
`include "xcvr_rst_regs.svh"
module xcvr_rst_seq_properties #(
  parameter int PWRDN_CYC = 100,
  parameter int RXDIG_CYC = 400,
  parameter int LTD_CYC = 1500
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire xcvr_rst_pkg::xcvr_stat_t i_stat,
  input wire xcvr_rst_pkg::xcvr_ctrl_t o_ctrl,
  input wire logic o_rx_data_valid,
  input wire logic [`RATE_W-1:0] o_rate_sel,
  input wire logic o_reconf_commit
);
  import xcvr_rst_pkg::*;
  logic [15:0] pd_r, ref_r, ltd_r;
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // run lengths of power-down, reference lock and lock-to-data
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      pd_r <= '0;
      ref_r <= '0;
      ltd_r <= '0;
    end else begin
      pd_r <= o_ctrl.pll_powerdown ? pd_r + 16'h1 : '0;
      ref_r <= i_stat.rx_ref_locked ? ref_r + 16'h1 : '0;
      ltd_r <= o_ctrl.lock_to_data ? ltd_r + 16'h1 : '0;
    end
  end
  sequence s_pulse2;
    o_ctrl.rx_logic_reset ##1 !o_ctrl.rx_logic_reset;
  endsequence
  property p_pd; $fell(o_ctrl.pll_powerdown) |-> pd_r >= PWRDN_CYC; endproperty
  property p_hold; o_ctrl.pll_powerdown |-> o_ctrl[4:2] == 3'h7; endproperty
  property p_tx; $fell(o_ctrl.tx_logic_reset) |-> $past(i_stat.pll_locked) && !$past(i_stat.busy); endproperty
  property p_fe; $fell(o_ctrl.rx_frontend_reset) |-> !$past(i_stat.busy); endproperty
  property p_ref; o_ctrl.pll_powerdown |-> o_ctrl.lock_to_ref && !o_ctrl.lock_to_data; endproperty
  property p_swap; $rose(o_ctrl.lock_to_data) |-> $fell(o_ctrl.lock_to_ref) && ref_r >= LTD_CYC; endproperty
  property p_ltd; $fell(o_ctrl.rx_logic_reset) && o_ctrl.lock_to_data |-> ltd_r >= RXDIG_CYC; endproperty
  property p_pulse; $rose(o_ctrl.rx_logic_reset) |=> s_pulse2; endproperty
  property p_valid; $fell(i_stat.rx_data_locked) |-> ##[1:2] !o_rx_data_valid; endproperty
  property p_commit; o_reconf_commit |-> o_ctrl.tx_logic_reset && $stable(o_rate_sel); endproperty
  a_pd: assert property (p_pd) else $error("power-down too short");
  a_hold: assert property (p_hold) else $error("reset low in power-down");
  a_tx: assert property (p_tx) else $error("tx reset released early");
  a_fe: assert property (p_fe) else $error("front-end released while busy");
  a_ref: assert property (p_ref) else $error("cdr mode wrong in power-down");
  a_swap: assert property (p_swap) else $error("lock swap wrong");
  a_ltd: assert property (p_ltd) else $error("rx logic released early");
  a_pulse: assert property (p_pulse) else $error("rx pulse not two cycles");
  a_valid: assert property (p_valid) else $error("data valid after lock loss");
  a_commit: assert property (p_commit) else $error("commit without held tx reset");
endmodule : xcvr_rst_seq_properties
bind xcvr_rst_seq xcvr_rst_seq_properties #(.PWRDN_CYC(PWRDN_CYC), .RXDIG_CYC(RXDIG_CYC), .LTD_CYC(LTD_CYC))
  u_props (.i_clock, .i_rst, .i_stat, .o_ctrl, .o_rx_data_valid, .o_rate_sel, .o_reconf_commit);

// ===== testbench/xcvr_far_model.sv
`timescale 1ns/1ps
module xcvr_far_model (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire xcvr_rst_pkg::xcvr_ctrl_t i_ctrl,
  input wire logic i_commit,
  input wire logic i_auto,
  input wire logic i_drop,
  output xcvr_rst_pkg::xcvr_stat_t o_stat,
  output logic o_phy_status
);
  import xcvr_rst_pkg::*;
  logic [3:0] busy_r;
  logic [2:0] pll_r;
  // one channel with its own flags; slow pll lock, busy after power-up
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      busy_r <= 4'h6;
      pll_r <= 3'h0;
      o_stat <= '0;
      o_phy_status <= 1'b0;
    end else begin
      pll_r <= i_ctrl.pll_powerdown ? 3'h0 : pll_r + {2'h0, pll_r != 3'h7};
      o_stat.pll_locked <= pll_r == 3'h7;
      o_stat.rx_ref_locked <= !i_ctrl.rx_frontend_reset && !i_drop;
      o_stat.rx_data_locked <= o_stat.rx_ref_locked && !i_drop && (i_auto || i_ctrl.lock_to_data);
      busy_r <= i_commit ? 4'h6 : busy_r - {3'h0, busy_r != 4'h0};
      o_stat.busy <= i_commit || busy_r > 4'h1;
      // phy status toggles once rx logic runs
      o_phy_status <= !i_ctrl.rx_logic_reset && !o_phy_status;
    end
  end
endmodule : xcvr_far_model

// ===== testbench/transceiver_reset_sequencer_tb.sv
`timescale 1ns/1ps
module transceiver_reset_sequencer_tb;
  import xcvr_rst_pkg::*;
  logic i_clock = 0, i_rst = 1, cyc = 0, stb = 0, we = 0, auto_m = 1, drop = 0;
  logic [7:0] adr = '0;
  logic [31:0] wdat = '0, rd, o_wb_dat;
  logic o_wb_ack, commit, valid, phy;
  logic [1:0] rate;
  xcvr_stat_t stat;
  xcvr_ctrl_t ctrl;
  int miscompares = 0, num_checks = 0, cycles = 0;
  always #5 i_clock = ~i_clock;
  xcvr_rst_seq #(.PWRDN_CYC(4), .RXDIG_CYC(4), .LTD_CYC(8)) u_xcvr_rst_seq (.i_clock(i_clock), .i_rst(i_rst),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_stat(stat), .o_ctrl(ctrl), .o_rate_sel(rate),
    .o_reconf_commit(commit), .o_rx_data_valid(valid));
  xcvr_far_model u_xcvr_far_model (.i_clock(i_clock), .i_rst(i_rst), .i_ctrl(ctrl), .i_commit(commit),
    .i_auto(auto_m), .i_drop(drop), .o_stat(stat), .o_phy_status(phy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  // classic single wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge i_clock); while (o_wb_ack !== 1'b1);
    rd = o_wb_dat;
    cyc <= 0;
    stb <= 0;
  endtask : wb
  task automatic wt(input int b, input logic v);
    int n;
    n = 0;
    while (ctrl[b] !== v && n < 4000) begin
      @(posedge i_clock);
      n++;
    end
    chk(ctrl[b], v);
  endtask : wt
  task automatic rst;
    i_rst <= 1;
    repeat (4) @(posedge i_clock);
    i_rst <= 0;
  endtask : rst
  task automatic t_auto;
    rst;
    chk(ctrl, 6'h3E);
    wb(0, 8'h0C, 0);
    chk(rd, 0);
    wb(1, 8'h00, 1);
    wt(2, 0);
    chk(stat.rx_data_locked, 1);
    chk(ctrl[4], 0);
    for (int r = 1; r < 4; r++) begin
      wb(1, 8'h08, r);
      wb(0, 8'h08, 0);
      chk(rd, r);
      wb(1, 8'h00, 8);
      wt(4, 1);
      chk(rate, r);
      @(posedge i_clock);
      chk(commit, 1);
      wt(4, 0);
      chk(stat.busy, 0);
      repeat (3) @(posedge i_clock);
    end
  endtask : t_auto
  task automatic t_manual;
    rst;
    auto_m <= 0;
    wb(1, 8'h00, 3);
    wt(0, 1);
    chk(ctrl[2:1], 2'h2);
    wt(2, 0);
    chk(valid, 1);
    wb(0, 8'h04, 0);
    chk(rd, {16'h0, 4'(ST_RUN), 12'h0E9});
    auto_m <= 1;
  endtask : t_manual
  task automatic t_pcie;
    logic was;
    rst;
    wb(1, 8'h00, 5);
    wb(0, 8'h00, 0);
    chk(rd, 32'h4);
    wt(2, 0);
    chk(valid, 1);
    was = phy;
    @(posedge i_clock);
    chk(phy, !was);
    drop <= 1;
    repeat (3) @(posedge i_clock);
    chk(valid, 0);
    drop <= 0;
    wt(2, 1);
    wt(2, 0);
    chk(valid, 1);
  endtask : t_pcie
  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    t_auto;
    t_manual;
    t_pcie;
    tally_and_finish;
  end
endmodule : transceiver_reset_sequencer_tb
